/* File: rtl/wcf_pkg.sv */
// Constants shared by the weld cycle process-image handler.
package wcf_pkg;
	// ==========================================================
	// Clock and timing
	// ==========================================================
	// Clock period in nanoseconds.
	localparam int CLK_PERIOD_NS = 25;
	// Timebase tick, one millisecond, in nanoseconds.
	localparam int TICK_TIME_NS = 1000000;
	// Clock cycles in one timebase tick.
	localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;
	// Weld time after reset, 5.0 s, in milliseconds.
	localparam logic [15:0] WELD_TIME_MS = 16'h1388;
	// Hold time after reset, 10.0 s, in milliseconds.
	localparam logic [15:0] HOLD_TIME_MS = 16'h2710;

	// ==========================================================
	// Process image layout
	// ==========================================================
	// Words in the input image returned to the controller.
	localparam int IMAGE_WORDS = 12;
	// Live telemetry words, image words 4 to 11.
	localparam int TELEM_WORDS = 8;

	// ==========================================================
	// Control and status word bits
	// ==========================================================
	// Automatic mode bit of the first control word.
	localparam int AUTO_BIT = 14;
	// Start command pattern in the second control word: weld function plus run.
	localparam logic [15:0] START_CMD = 16'h0201;
	// First status word base value.
	localparam logic [15:0] STAT_ONE_BASE = 16'h0010;
	// Second status word values per state.
	localparam logic [15:0] STAT_TWO_IDLE = 16'h0400;
	localparam logic [15:0] STAT_TWO_WELD = 16'h0800;
	localparam logic [15:0] STAT_TWO_HOLD = 16'h0000;
	localparam logic [15:0] STAT_TWO_END = 16'h1400;
	localparam logic [15:0] STAT_TWO_ALARM = 16'h1008;

	// ==========================================================
	// Register map
	// ==========================================================
	localparam logic [7:0] REG_WELD_TIME = 8'h00;
	localparam logic [7:0] REG_HOLD_TIME = 8'h04;
	localparam logic [7:0] REG_CYCLE_STATE = 8'h08;

	// Weld cycle states.
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_WELD = 3'b001,
		ST_HOLD = 3'b010,
		ST_END = 3'b011,
		ST_ALARM = 3'b100
	} wcf_state_type;
endpackage

/* File: rtl/wcf_weld_cycle.sv */
// Weld cycle process-image handler: control word decode, timed weld and status words.
//
// The placing of the registers and the plain strobed port were chosen for this implementation.
`timescale 1ns/100ps
module wcf_weld_cycle #(
	parameter int TICK_CYCLES = wcf_pkg::TICK_CYCLES
) (
	// Clock, reset and clock enable.
	input wire logic clk_i,
	input wire logic srst_i,
	input wire logic ce_i,
	// Output image from the controller.
	input wire logic [15:0] control_word_one_i,
	input wire logic [15:0] control_word_two_i,
	input wire logic [15:0] ext_amplitude_i,
	input wire logic [15:0] freq_offset_i,
	// Live telemetry, word n at bits 16n+15 to 16n.
	input wire logic [16*wcf_pkg::TELEM_WORDS-1:0] telem_i,
	// Input image to the controller, word n at bits 16n+15 to 16n.
	output logic [16*wcf_pkg::IMAGE_WORDS-1:0] image_o,
	// Ultrasonics drive request and received set values.
	output logic sonics_on_o,
	output logic [15:0] ext_amplitude_o,
	output logic [15:0] freq_offset_o,
	// Diagnostic view of control and status words.
	output logic [15:0] diag_control_one_o,
	output logic [15:0] diag_control_two_o,
	output logic [15:0] diag_status_one_o,
	output logic [15:0] diag_status_two_o,
	// Register port.
	input wire logic [7:0] reg_addr_i,
	input wire logic [31:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [31:0] reg_rdata_o
);
	// ==========================================================
	// Declarations
	// ==========================================================
	// Cycle state and its next value.
	wcf_pkg::wcf_state_type state;
	wcf_pkg::wcf_state_type next_state;
	// Configured weld and hold times in milliseconds.
	logic [15:0] weld_ms;
	logic [15:0] hold_ms;
	// Milliseconds left in the current phase.
	logic [15:0] ms_left;
	// Cycles within the current millisecond.
	logic [31:0] tick_cnt;
	// Status words as built from the state and the automatic mode bit.
	logic [15:0] status_one;
	logic [15:0] status_two;
	logic [15:0] next_status_two;
	// Decoded commands and timer conditions.
	logic auto_mode;
	logic start_cmd;
	logic tick;
	logic phase_done;

	// A start needs automatic mode and the exact start pattern.
	assign auto_mode = control_word_one_i[wcf_pkg::AUTO_BIT];
	assign start_cmd = auto_mode && (control_word_two_i == wcf_pkg::START_CMD);
	// One millisecond has elapsed.
	assign tick = (tick_cnt == 32'(TICK_CYCLES - 1));
	// The phase ends once no milliseconds are left.
	assign phase_done = (ms_left == 16'h0000);

	// ==========================================================
	// Cycle sequencer
	// ==========================================================
	// Next state: weld, then hold, then end or alarm.
	always_comb begin
		next_state = state;
		case (state)
			wcf_pkg::ST_IDLE, wcf_pkg::ST_END: begin
				// A start command, new or still held, begins the weld.
				if (start_cmd) begin
					next_state = wcf_pkg::ST_WELD;
				end
			end
			wcf_pkg::ST_WELD: begin
				// Losing automatic mode aborts the cycle.
				if (!auto_mode) begin
					next_state = wcf_pkg::ST_END;
				end else if (phase_done) begin
					next_state = wcf_pkg::ST_HOLD;
				end
			end
			wcf_pkg::ST_HOLD: begin
				// Start still held at the end of hold is an alarm.
				if (!auto_mode) begin
					next_state = wcf_pkg::ST_END;
				end else if (phase_done && start_cmd) begin
					next_state = wcf_pkg::ST_ALARM;
				end else if (phase_done) begin
					next_state = wcf_pkg::ST_END;
				end
			end
			wcf_pkg::ST_ALARM: begin
				// The alarm clears once the start is released.
				if (!start_cmd) begin
					next_state = wcf_pkg::ST_END;
				end
			end
			default: begin
				next_state = wcf_pkg::ST_IDLE;
			end
		endcase
	end

	// State register.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			state <= wcf_pkg::ST_IDLE;
		end else if (ce_i) begin
			state <= next_state;
		end
	end

	// Phase timer: loads on each phase entry and counts milliseconds down.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			ms_left <= 16'h0000;
			tick_cnt <= 32'h0000_0000;
		end else if (ce_i) begin
			if (next_state != state) begin
				// A new phase restarts both counters.
				tick_cnt <= 32'h0000_0000;
				ms_left <= (next_state == wcf_pkg::ST_WELD) ? weld_ms : hold_ms;
			end else if (tick) begin
				tick_cnt <= 32'h0000_0000;
				if (!phase_done) begin
					ms_left <= ms_left - 16'h0001;
				end
			end else begin
				tick_cnt <= tick_cnt + 32'h0000_0001;
			end
		end
	end

	// ==========================================================
	// Status words and image
	// ==========================================================
	// Second status word value for each state.
	always_comb begin
		case (state)
			wcf_pkg::ST_IDLE: next_status_two = wcf_pkg::STAT_TWO_IDLE;
			wcf_pkg::ST_WELD: next_status_two = wcf_pkg::STAT_TWO_WELD;
			wcf_pkg::ST_HOLD: next_status_two = wcf_pkg::STAT_TWO_HOLD;
			wcf_pkg::ST_END: next_status_two = wcf_pkg::STAT_TWO_END;
			wcf_pkg::ST_ALARM: next_status_two = wcf_pkg::STAT_TWO_ALARM;
			default: next_status_two = wcf_pkg::STAT_TWO_IDLE;
		endcase
	end

	// Status words; the first reports automatic mode back in bit 14, beside base bit 4.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			status_one <= wcf_pkg::STAT_ONE_BASE;
			status_two <= wcf_pkg::STAT_TWO_IDLE;
		end else if (ce_i) begin
			status_one <= wcf_pkg::STAT_ONE_BASE | {1'b0, auto_mode, 14'h0000};
			status_two <= next_status_two;
		end
	end

	// Input image: reserved words zero, status words, then telemetry.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			image_o <= '0;
		end else if (ce_i) begin
			image_o[31:0] <= 32'h0000_0000;
			image_o[47:32] <= status_one;
			image_o[63:48] <= status_two;
			// Telemetry passes whatever the cycle state is.
			image_o[16*wcf_pkg::IMAGE_WORDS-1:64] <= telem_i;
		end
	end

	// Ultrasonics run only in the weld phase; set values pass through.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			sonics_on_o <= 1'b0;
			ext_amplitude_o <= 16'h0000;
			freq_offset_o <= 16'h0000;
		end else if (ce_i) begin
			sonics_on_o <= (next_state == wcf_pkg::ST_WELD);
			ext_amplitude_o <= ext_amplitude_i;
			freq_offset_o <= freq_offset_i;
		end
	end

	// Diagnostic view mirrors received control words and returned status words.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			diag_control_one_o <= 16'h0000;
			diag_control_two_o <= 16'h0000;
			diag_status_one_o <= wcf_pkg::STAT_ONE_BASE;
			diag_status_two_o <= wcf_pkg::STAT_TWO_IDLE;
		end else if (ce_i) begin
			diag_control_one_o <= control_word_one_i;
			diag_control_two_o <= control_word_two_i;
			diag_status_one_o <= status_one;
			diag_status_two_o <= status_two;
		end
	end

	// ==========================================================
	// Register port
	// ==========================================================
	// Writes set the phase times in milliseconds.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			weld_ms <= wcf_pkg::WELD_TIME_MS;
			hold_ms <= wcf_pkg::HOLD_TIME_MS;
		end else if (ce_i && reg_wr_i) begin
			if (reg_addr_i == wcf_pkg::REG_WELD_TIME) begin
				weld_ms <= reg_wdata_i[15:0];
			end
			if (reg_addr_i == wcf_pkg::REG_HOLD_TIME) begin
				hold_ms <= reg_wdata_i[15:0];
			end
		end
	end

	// Reads answer one cycle later; unmapped addresses read zero.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			reg_rdata_o <= 32'h0000_0000;
		end else if (ce_i) begin
			reg_rdata_o <= 32'h0000_0000;
			if (reg_rd_i) begin
				case (reg_addr_i)
					wcf_pkg::REG_WELD_TIME: reg_rdata_o <= {16'h0000, weld_ms};
					wcf_pkg::REG_HOLD_TIME: reg_rdata_o <= {16'h0000, hold_ms};
					wcf_pkg::REG_CYCLE_STATE: reg_rdata_o <= {13'h0000, state, status_two};
					default: reg_rdata_o <= 32'h0000_0000;
				endcase
			end
		end
	end

	// ==========================================================
	// Assertions
	// ==========================================================
	// Attempts that start on the last reset edge are skipped: reset clears the image there, not the status words.
	image_layout_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && !srst_i |=> image_o[63:48] == $past(status_two) && image_o[31:0] == 32'h0000_0000)
		else $error("Status words misplaced in input image.");
	telem_path_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && !srst_i |=> image_o[79:64] == $past(telem_i[15:0]) && image_o[191:176] == $past(telem_i[127:112]))
		else $error("Telemetry words out of order.");
	idle_words_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_IDLE && control_word_one_i == 16'h0000 |=> status_one == 16'h0010
		&& status_two == 16'h0400)
		else $error("Idle status words wrong.");
	start_weld_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_IDLE && start_cmd |=> state == wcf_pkg::ST_WELD)
		else $error("Start command did not begin weld.");
	hold_off_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_HOLD |=> status_two == 16'h0000 && !sonics_on_o)
		else $error("Hold phase reports ultrasonics on.");
	end_word_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_HOLD && phase_done && auto_mode && !start_cmd
		|=> state == wcf_pkg::ST_END ##1 (status_two == 16'h1400 || !$past(ce_i)))
		else $error("End of cycle not reported.");
	alarm_word_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_HOLD && phase_done && start_cmd |=> state == wcf_pkg::ST_ALARM)
		else $error("Held start raised no alarm.");
	diag_mirror_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && !srst_i |=> diag_control_two_o == $past(control_word_two_i) && diag_status_two_o == $past(status_two))
		else $error("Diagnostic view does not mirror words.");
	weld_timer_a: assert property (@(posedge clk_i) disable iff (srst_i)
		ce_i && state == wcf_pkg::ST_WELD && !phase_done && auto_mode |=> state == wcf_pkg::ST_WELD)
		else $error("Weld phase ended early.");
endmodule

/* File: verification/testbench.sv */
// Self-checking testbench for the weld cycle process-image handler.
`timescale 1ns/100ps
module testbench;
	// ==========================================================
	// Signals
	// ==========================================================
	logic clk_i = 1'b0;
	logic srst_i = 1'b1;
	logic auto = 1'b0;
	logic start = 1'b0;
	logic [15:0] cw1, cw2, ampl, foff, ampl_q, foff_q, dc1, dc2, ds1, ds2;
	logic [127:0] telem = 128'h0021_75f2_0000_0000_0000_0000_0000_004a;
	logic [191:0] image;
	logic sonics;
	logic [7:0] reg_addr_i = 8'h00;
	logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o;
	logic reg_wr_i = 1'b0;
	logic reg_rd_i = 1'b0;
	int failures = 0;
	int checked = 0;
	// Image word 3 is the second status word.
	wire [15:0] w3 = image[63:48];
	// The clock runs at 40 MHz.
	always #12.5 clk_i = ~clk_i;
	// ==========================================================
	// Instances
	// ==========================================================
	wcf_plc_model u_plc (.clk_i(clk_i), .srst_i(srst_i), .auto_i(auto), .start_i(start),
		.control_word_one_o(cw1), .control_word_two_o(cw2), .ext_amplitude_o(ampl), .freq_offset_o(foff));
	// A tick of four cycles keeps millisecond counts short.
	wcf_weld_cycle #(.TICK_CYCLES(4)) u_dut (.clk_i(clk_i), .srst_i(srst_i), .ce_i(1'b1),
		.control_word_one_i(cw1), .control_word_two_i(cw2), .ext_amplitude_i(ampl), .freq_offset_i(foff),
		.telem_i(telem), .image_o(image), .sonics_on_o(sonics), .ext_amplitude_o(ampl_q),
		.freq_offset_o(foff_q), .diag_control_one_o(dc1), .diag_control_two_o(dc2),
		.diag_status_one_o(ds1), .diag_status_two_o(ds2), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
	// ==========================================================
	// Shared tasks
	// ==========================================================
	// Counts a comparison and reports it when the values differ.
	task check(input string name, input logic [127:0] seen, input logic [127:0] exp);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("unexpected %s expected %h seen %h", name, exp, seen);
		end
	endtask
	// Prints the counts and the verdict, then stops.
	task final_report();
		$display("checked %0d failures %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// One write cycle on the register port.
	task reg_write(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
	endtask
	// One read cycle; data is looked at in the cycle after the strobe only.
	task reg_read(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		check("reg_rdata", reg_rdata_o, exp);
	endtask
	// Waits a bounded time for the second status word; a timeout ends the run.
	task wait_w3(input logic [15:0] exp, input int bound);
		int i;
		for (i = 0; i < bound && w3 !== exp; i++) @(posedge clk_i);
		check("status_word_two", w3, exp);
		if (w3 !== exp) final_report();
	endtask
	// ==========================================================
	// Scenarios
	// ==========================================================
	// Idle image, telemetry and register reset values with no command sent.
	task test_idle();
		repeat (4) @(posedge clk_i);
		check("reserved", image[31:0], 32'h0);
		check("status_one", image[47:32], 32'h0010);
		check("status_two", w3, 32'h0400);
		check("telemetry", image[191:64], telem);
		check("diag", {dc1, dc2, ds1, ds2}, 64'h0000_0000_0010_0400);
		check("set values", {ampl_q, foff_q}, 32'h0032_000a);
		reg_read(8'h00, 32'h1388);
		reg_read(8'h04, 32'h2710);
		reg_read(8'h08, 32'h0000_0400);
		reg_read(8'h0c, 32'h0);
		$display("idle test done");
	endtask
	// Timed weld, hold and release: three ticks of weld, two of hold.
	task test_cycle();
		int n;
		reg_write(8'h00, 32'hffff_0003);
		reg_write(8'h04, 32'h0000_0002);
		reg_read(8'h00, 32'h0003);
		auto <= 1'b1;
		start <= 1'b1;
		wait_w3(16'h0800, 10);
		repeat (2) @(posedge clk_i);
		check("status_one auto", image[47:32], 32'h4010);
		check("diag control", {dc1, dc2, ds2}, 48'h4000_0201_0800);
		check("sonics on", sonics, 1'b1);
		check("telemetry live", image[191:64], telem);
		for (n = 0; n < 40 && sonics === 1'b1; n++) @(posedge clk_i);
		check("weld length", (n >= 9 && n <= 13), 1'b1);
		// A weld that never ends has used up the bound and closes the run.
		if (n == 40) final_report();
		wait_w3(16'h0000, 4);
		start <= 1'b0;
		wait_w3(16'h1400, 20);
		$display("cycle test done");
	endtask
	// Start held past the end of the cycle raises the alarm until released.
	task test_alarm();
		start <= 1'b1;
		wait_w3(16'h0800, 10);
		wait_w3(16'h0000, 20);
		wait_w3(16'h1008, 20);
		repeat (3) @(posedge clk_i);
		check("alarm stands", w3, 32'h1008);
		start <= 1'b0;
		wait_w3(16'h1400, 10);
		$display("alarm test done");
	endtask
	// Main sequence.
	initial begin
		repeat (4) @(posedge clk_i);
		srst_i <= 1'b0;
		test_idle();
		test_cycle();
		test_alarm();
		final_report();
	end
endmodule

/* File: verification/wcf_plc_model.sv */
// Controller model that scans the output image into the weld cycle block.
`timescale 1ns/100ps
module wcf_plc_model (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic srst_i,
	// Requests from the bench.
	input wire logic auto_i,
	input wire logic start_i,
	// Output image words.
	output logic [15:0] control_word_one_o,
	output logic [15:0] control_word_two_o,
	output logic [15:0] ext_amplitude_o,
	output logic [15:0] freq_offset_o
);
	// ==========================================================
	// Cyclic image update
	// ==========================================================
	// Words change only just after a rising edge, as a scanner update would.
	always_ff @(posedge clk_i) begin
		if (srst_i) begin
			control_word_one_o <= 16'h0000;
			control_word_two_o <= 16'h0000;
			ext_amplitude_o <= 16'h0000;
			freq_offset_o <= 16'h0000;
		end else begin
			control_word_one_o <= auto_i ? 16'h4000 : 16'h0000;
			control_word_two_o <= start_i ? 16'h0201 : 16'h0000;
			ext_amplitude_o <= 16'h0032;
			freq_offset_o <= 16'h000a;
		end
	end
endmodule
